// [sobr_pkg.sv]
// Package for the sign/overflow conditional branch unit.
// Assumes one clock domain; opcodes are local to this processor core.
package sobr_pkg;
  localparam int SOBR_PC_W = 16;
  localparam int SOBR_OP_W = 8;
  // Branch kinds
  typedef enum logic [1:0] {
    SOBR_NEG,
    SOBR_POS,
    SOBR_OVR_CLR,
    SOBR_OVR_SET
  } sobr_kind_type;
  // Encoded lengths in bytes
  localparam logic [1:0] SOBR_LEN_REL = 2'h2;
  localparam logic [1:0] SOBR_LEN_ABS = 2'h3;
  // Execution lengths in cycles
  localparam logic [2:0] SOBR_CYC_REL = 3'h3;
  localparam logic [2:0] SOBR_CYC_ABS = 3'h4;
  // Opcode values; relative forms, absolute form sets bit 3
  localparam logic [7:0] SOBR_OPC_NEG = 8'h40;
  localparam logic [7:0] SOBR_OPC_POS = 8'h41;
  localparam logic [7:0] SOBR_OPC_OVC = 8'h42;
  localparam logic [7:0] SOBR_OPC_OVS = 8'h43;
  localparam logic [7:0] SOBR_OPC_ABS_BIT = 8'h08;
  localparam int SOBR_ABS_POS = 3;
endpackage : sobr_pkg

// [sobr_decode.sv]
// Opcode decoder for the sign/overflow branch unit.
// Assumes opcode byte is stable while issue is high.
`timescale 1ns/1ps
`default_nettype none
module sobr_decode
  import sobr_pkg::*;
(
  input wire logic [SOBR_OP_W-1:0] opcode,
  output logic hit,
  output logic is_abs,
  output sobr_kind_type kind
);
  logic [7:0] base;
  always_comb begin
    base = opcode & ~SOBR_OPC_ABS_BIT;
    is_abs = opcode[SOBR_ABS_POS];
    hit = 1'b1;
    kind = SOBR_NEG;
    case (base)
      SOBR_OPC_NEG: kind = SOBR_NEG;
      SOBR_OPC_POS: kind = SOBR_POS;
      SOBR_OPC_OVC: kind = SOBR_OVR_CLR;
      SOBR_OPC_OVS: kind = SOBR_OVR_SET;
      default: hit = 1'b0;
    endcase
  end
endmodule : sobr_decode
`default_nettype wire

// [sobr_branch.sv]
// Sign/overflow conditional branch unit of the embedded processor.
// Assumes the fetch stage presents the opcode and operand bytes at issue,
// and that flags are stable for the duration of the instruction.
//
// Summary of operation
// RULE1 - Negative branch taken when sign flag is one
// RULE2 - Positive branch taken when sign flag is zero
// RULE3 - Overflow-clear branch taken when overflow is zero
// RULE4 - Overflow-set branch taken when overflow is one
// RULE5 - Relative form two bytes, absolute three
// RULE6 - Relative form three cycles, absolute four
// RULE7 - Label target resolves to PC when taken
// RULE8 - Not taken falls through; flags untouched
`timescale 1ns/1ps
`default_nettype none
module sobr_branch
  import sobr_pkg::*;
#(
  parameter int PC_W = SOBR_PC_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [SOBR_OP_W-1:0] opcode,
  input wire logic [7:0] operand_lo,
  input wire logic [7:0] operand_hi,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic flag_sign,
  input wire logic flag_overflow,
  output logic busy,
  output logic done,
  output logic pc_load,
  output logic [PC_W-1:0] pc_next,
  output logic [1:0] instr_len,
  output logic taken
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic hit;
  logic is_abs;
  sobr_kind_type kind;

  sobr_decode u_sobr_decode (
    .opcode(opcode),
    .hit(hit),
    .is_abs(is_abs),
    .kind(kind)
  );

  logic cond;
  always_comb begin
    case (kind)
      SOBR_NEG: cond = flag_sign; // RULE1
      SOBR_POS: cond = ~flag_sign; // RULE2
      SOBR_OVR_CLR: cond = ~flag_overflow; // RULE3
      SOBR_OVR_SET: cond = flag_overflow; // RULE4
      default: cond = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC} sobr_state_type;

  logic accept;
  logic last_cyc;
  logic [1:0] len_sel;
  logic [2:0] cyc_sel;
  logic [PC_W-1:0] len_ext;
  logic [PC_W-1:0] rel_off;
  logic [PC_W-1:0] abs_tgt;
  logic [PC_W-1:0] fall;
  logic [PC_W-1:0] target;

  ////////////////////////////////////////////////////////////////////////
  // Target and length, resolved in the issue cycle

  always_comb begin
    len_sel = is_abs ? SOBR_LEN_ABS : SOBR_LEN_REL; // RULE5
    cyc_sel = is_abs ? SOBR_CYC_ABS : SOBR_CYC_REL; // RULE6
    len_ext = PC_W'(len_sel);
    // Signed offset, counted from the address after the branch
    rel_off = PC_W'($signed(operand_lo));
    abs_tgt = PC_W'({operand_hi, operand_lo});
    fall = pc_in + len_ext; // RULE8
    target = is_abs ? abs_tgt : fall + rel_off; // RULE7
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  sobr_state_type state_r;
  sobr_state_type state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // Issue while busy, or with a foreign opcode, is dropped without a trace
  assign accept = issue && hit && (state_r == ST_IDLE);
  assign last_cyc = (state_r == ST_EXEC) && (cnt_r == 3'h1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_EXEC;
          // Count includes the issue cycle
          cnt_nxt = cyc_sel - 3'h1; // RULE6
        end
      end
      ST_EXEC: begin
        cnt_nxt = cnt_r - 3'h1;
        if (last_cyc) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status strobes

  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  logic load_r;
  logic load_nxt;

  always_comb begin
    busy_nxt = 1'b0;
    done_nxt = 1'b0;
    load_nxt = 1'b0;
    // Busy follows the sequencer, so a stray state cannot leave it stuck
    case (state_nxt)
      ST_EXEC: busy_nxt = 1'b1;
      default: busy_nxt = 1'b0;
    endcase
    if (last_cyc) begin
      done_nxt = 1'b1;
      // Fall-through is loaded too, so fetch has a single redirect path
      load_nxt = 1'b1; // RULE1 RULE2 RULE3 RULE4 RULE8
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      load_r <= load_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Results, held until the next accepted issue

  logic taken_r;
  logic taken_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [1:0] len_r;
  logic [1:0] len_nxt;

  always_comb begin
    taken_nxt = taken_r;
    pc_nxt = pc_r;
    len_nxt = len_r;
    if (accept) begin
      taken_nxt = cond; // RULE1 RULE2 RULE3 RULE4
      len_nxt = len_sel; // RULE5
      // Flags are only read, never written
      if (cond) begin
        pc_nxt = target; // RULE7
      end else begin
        pc_nxt = fall; // RULE8
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      taken_r <= 1'b0;
      pc_r <= '0;
      len_r <= 2'h0;
    end else begin
      taken_r <= taken_nxt;
      pc_r <= pc_nxt;
      len_r <= len_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from its register

  assign busy = busy_r;
  assign done = done_r;
  assign pc_load = load_r;
  assign pc_next = pc_r;
  assign instr_len = len_r;
  assign taken = taken_r;

endmodule : sobr_branch
`default_nettype wire

// [sobr_checker.sv]
// Assertions for the sign/overflow branch unit.
// Bound to sobr_branch; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sobr_checker
  import sobr_pkg::*;
#(
  parameter int PC_W = SOBR_PC_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire logic [SOBR_OP_W-1:0] opcode,
  input wire logic flag_sign,
  input wire logic flag_overflow,
  input wire logic busy,
  input wire logic done,
  input wire logic pc_load,
  input wire logic [1:0] instr_len,
  input wire logic taken
);
  // Accepted issue: idle and one of the eight branch opcodes
  logic acc;
  assign acc = issue && !busy && opcode[7:4] == 4'h4 && !opcode[2];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_rel_done_time: assert property (acc && !opcode[3] |=> !done [*2] ##1 done)
    else $error("relative done timing");
  a_abs_done_time: assert property (acc && opcode[3] |=> !done [*3] ##1 done)
    else $error("absolute done timing");
  a_neg_cond: assert property (acc && opcode[1:0] == 2'h0
    |=> taken == $past(flag_sign))
    else $error("negative condition");
  a_pos_cond: assert property (acc && opcode[1:0] == 2'h1
    |=> taken == !$past(flag_sign))
    else $error("positive condition");
  a_ovc_cond: assert property (acc && opcode[1:0] == 2'h2
    |=> taken == !$past(flag_overflow))
    else $error("overflow clear condition");
  a_ovs_cond: assert property (acc && opcode[1:0] == 2'h3
    |=> taken == $past(flag_overflow))
    else $error("overflow set condition");
  a_len_form: assert property (acc |=> instr_len == ($past(opcode[3]) ? 2'h3 : 2'h2))
    else $error("length by form");
  a_load_pulse: assert property (done |-> pc_load ##1 !done)
    else $error("load pulse");
  a_busy_hold: assert property (acc |=> busy [*2])
    else $error("busy during branch");
  a_done_idle: assert property (done |-> !busy)
    else $error("busy at done");
  a_busy_refuse: assert property (issue && busy |=> $stable(taken) && $stable(instr_len))
    else $error("issue taken while busy");
endmodule : sobr_checker
bind sobr_branch sobr_checker #(.PC_W(PC_W)) u_sobr_checker (.ref_clk(ref_clk), .rst_n(rst_n),
  .issue(issue), .opcode(opcode), .flag_sign(flag_sign), .flag_overflow(flag_overflow),
  .busy(busy), .done(done), .pc_load(pc_load), .instr_len(instr_len), .taken(taken));
`default_nettype wire

// [sobr_branch_tb.sv]
// Testbench for the sign/overflow branch unit.
// Drives all ports itself; the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module sobr_branch_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, issue = 1'b0, flag_sign = 1'b0, flag_overflow = 1'b0;
  logic [7:0] opcode = 8'h00, operand_lo = 8'h00, operand_hi = 8'h00;
  logic [15:0] pc_in = 16'h1000;
  logic busy, done, pc_load, taken;
  logic [15:0] pc_next;
  logic [1:0] instr_len;
  int fails = 0, samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  sobr_branch u_sobr_branch (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue), .opcode(opcode),
    .operand_lo(operand_lo), .operand_hi(operand_hi), .pc_in(pc_in), .flag_sign(flag_sign),
    .flag_overflow(flag_overflow), .busy(busy), .done(done), .pc_load(pc_load),
    .pc_next(pc_next), .instr_len(instr_len), .taken(taken));
  ////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, a);
    samples_checked++;
    if (a !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, a);
    end
  endtask : chk
  // Next issue follows one cycle after the done pulse
  task automatic run(input logic [7:0] op, lo, hi, input logic s, v, tk);
    int n;
    logic [15:0] len;
    logic [15:0] cyc;
    logic [15:0] tgt;
    len = op[3] ? 16'h0003 : 16'h0002;
    cyc = op[3] ? 16'h0004 : 16'h0003;
    tgt = op[3] ? {hi, lo} : pc_in + 16'h0002 + {{8{lo[7]}}, lo};
    @(negedge ref_clk);
    {opcode, operand_lo, operand_hi, flag_sign, flag_overflow, issue} = {op, lo, hi, s, v, 1'b1};
    @(negedge ref_clk);
    issue = 1'b0;
    chk("busy", 16'h0001, {15'h0, busy});
    n = 1;
    while (done !== 1'b1 && n < 9) begin
      @(negedge ref_clk);
      n++;
    end
    chk("cycles", cyc, 16'(n));
    chk("idle", 16'h0000, {15'h0, busy});
    chk("taken", 16'(tk), 16'(taken));
    chk("len", len, {14'h0, instr_len});
    chk("load", 16'h0001, {15'h0, pc_load});
    chk("pc", tk ? tgt : pc_in + len, pc_next);
  endtask : run
  task t_sign;
    run(8'h40, 8'hF0, 8'h00, 1'b1, 1'b0, 1'b1);
    run(8'h48, 8'h34, 8'h12, 1'b0, 1'b1, 1'b0);
    run(8'h49, 8'hCD, 8'hAB, 1'b0, 1'b0, 1'b1);
    run(8'h41, 8'h7F, 8'h00, 1'b1, 1'b0, 1'b0);
  endtask : t_sign
  task t_ovr;
    run(8'h42, 8'h7F, 8'h00, 1'b1, 1'b0, 1'b1);
    run(8'h4A, 8'h00, 8'hFF, 1'b0, 1'b1, 1'b0);
    run(8'h4B, 8'hFF, 8'h00, 1'b0, 1'b1, 1'b1);
    run(8'h43, 8'h80, 8'h00, 1'b1, 1'b0, 1'b0);
  endtask : t_ovr
  // A second issue while busy must leave the running branch alone
  task automatic t_refuse;
    int n;
    @(negedge ref_clk);
    {opcode, operand_lo, operand_hi, flag_sign, issue} = {8'h48, 8'h21, 8'h43, 1'b1, 1'b1};
    @(negedge ref_clk);
    {opcode, operand_lo} = {8'h41, 8'h10};
    n = 1;
    while (done !== 1'b1 && n < 9) begin
      @(negedge ref_clk);
      issue = 1'b0;
      n++;
    end
    chk("refused_cycles", 16'h0004, 16'(n));
    chk("refused_taken", 16'h0001, 16'(taken));
    chk("refused_len", 16'h0003, {14'h0, instr_len});
    chk("refused_pc", 16'h4321, pc_next);
  endtask : t_refuse
  // Reset in mid-branch clears every output and drops the branch
  task automatic t_reset;
    @(negedge ref_clk);
    {opcode, operand_lo, flag_overflow, issue} = {8'h4B, 8'h55, 1'b1, 1'b1};
    @(negedge ref_clk);
    {issue, rst_n} = 2'b00;
    repeat (2) @(negedge ref_clk);
    chk("reset_flags", 16'h0000, {10'h0, busy, done, pc_load, taken, instr_len});
    chk("reset_pc", 16'h0000, pc_next);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk("release_flags", 16'h0000, {10'h0, busy, done, pc_load, taken, instr_len});
    run(8'h43, 8'h05, 8'h00, 1'b0, 1'b1, 1'b1);
  endtask : t_reset
  task stop_test;
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    t_sign;
    t_ovr;
    t_refuse;
    t_reset;
    stop_test;
  end
  // Eleven branches take under 100 cycles; far more is a hang
  initial begin
    #4000;
    fails++;
    stop_test;
  end
endmodule : sobr_branch_tb
`default_nettype wire
